// File: dv/analog_front_model.sv
`timescale 1ns/1ps
module analog_front_model (
    input wire logic core_clk_in,
    input wire logic [1:0] pattern_in,
    output logic mod_bit_out
);
    logic toggle_q;
    initial toggle_q = 1'b0;
    always @(posedge core_clk_in)
    begin
        toggle_q <= ~toggle_q;
    end
    // 0: below zero, 1: above zero, 2: mid-scale bitstream
    always_comb
    begin
        case (pattern_in)
            2'h0: mod_bit_out = 1'b0;
            2'h1: mod_bit_out = 1'b1;
            default: mod_bit_out = toggle_q;
        endcase
    end
endmodule // analog_front_model

// File: dv/delta_sigma_adc_control_tb_top.sv
`timescale 1ns/1ps
module delta_sigma_adc_control_tb_top;
    logic core_clk_in, rst_in, wr_in, rd_in, irq_ack_in, mod_bit;
    logic [2:0] addr_in;
    logic [7:0] wdata_in, rdata_out, v;
    logic irq_out, bg, reg_on, cm, amp, modu, temp, nbuf, pbuf, fon, hold;
    logic ref_sel, tick;
    logic [1:0] pattern;
    int fails, total_checks, n;
    // c0, power/irq, {reg,bandgap,amp,mod,cm_gen,hold,ref}
    localparam logic [22:0] rows [7] = '{
        {8'h20, 8'h00, 7'h00}, {8'h20, 8'h01, 7'h60},
        {8'h40, 8'h00, 7'h30}, {8'h01, 8'h00, 7'h3d},
        {8'h80, 8'h00, 7'h3e}, {8'he0, 8'h00, 7'h00},
        {8'h41, 8'h01, 7'h71}};
    localparam logic [4:0] divs [3] = '{5'h00, 5'h01, 5'h1f};
    localparam int ticks [3] = '{200, 100, 400};

    delta_sigma_adc_control uut (.core_clk_in(core_clk_in), .rst_in(rst_in),
        .addr_in(addr_in), .wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in),
        .rdata_out(rdata_out), .mod_bit_in(mod_bit), .irq_ack_in(irq_ack_in),
        .irq_out(irq_out), .bandgap_on_out(bg), .regulator_on_out(reg_on),
        .cm_gen_on_out(cm), .amp_on_out(amp), .modulator_on_out(modu),
        .temp_sensor_on_out(temp), .neg_ref_buffer_on_out(nbuf),
        .pos_ref_buffer_on_out(pbuf), .filter_on_out(fon),
        .filter_hold_out(hold), .reference_pair_sel_out(ref_sel),
        .conv_clk_tick_out(tick));
    analog_front_model front (.core_clk_in(core_clk_in),
        .pattern_in(pattern), .mod_bit_out(mod_bit));

    initial
    begin
        core_clk_in = 1'b0;
        forever #10 core_clk_in = ~core_clk_in;
    end

    task automatic check(input string name, input logic [23:0] seen,
                         input logic [23:0] exp);
        total_checks++;
        if (seen !== exp)
        begin
            fails++;
            $display("MISMATCH %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic report_and_stop();
        if (fails == 0 && total_checks > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask

    task automatic wr(input logic [2:0] a, input logic [7:0] d);
        @(posedge core_clk_in);
        addr_in <= a;
        wdata_in <= d;
        wr_in <= 1'b1;
        @(posedge core_clk_in);
        wr_in <= 1'b0;
    endtask

    task automatic rd(input logic [2:0] a);
        @(posedge core_clk_in);
        addr_in <= a;
        rd_in <= 1'b1;
        @(posedge core_clk_in);
        rd_in <= 1'b0;
        #1 v = rdata_out;
    endtask

    task automatic idle(input int c);
        repeat (c) @(posedge core_clk_in);
        #1;
    endtask

    task automatic wait_irq();
        int i;
        for (i = 0; i < 2000 && irq_out !== 1'b1; i++)
        begin
            @(posedge core_clk_in);
            #1;
        end
        if (irq_out !== 1'b1)
        begin
            check("irq wait", 24'h0, 24'h1);
            report_and_stop();
        end
    endtask

    task automatic rd_result(input logic [23:0] exp);
        logic [23:0] r;
        rd(3'h0);
        r[7:0] = v;
        rd(3'h1);
        r[15:8] = v;
        rd(3'h2);
        r[23:16] = v;
        check("result", r, exp);
    endtask

    initial
    begin
        fails = 0;
        total_checks = 0;
        rst_in = 1'b1;
        {wr_in, rd_in, irq_ack_in} = 3'h0;
        addr_in = 3'h0;
        wdata_in = 8'h00;
        pattern = 2'h1;
        idle(20);
        rst_in <= 1'b0;
        rd(3'h3);
        check("control_0 reset", v, 8'h20);
        foreach (rows[i])
        begin
            wr(3'h3, rows[i][22:15]);
            wr(3'h7, rows[i][14:7]);
            idle(3);
            check("power", {reg_on, bg, amp, modu, cm, hold, ref_sel},
                  rows[i][6:0]);
        end
        foreach (divs[i])
        begin
            wr(3'h5, {3'h0, divs[i]});
            idle(20);
            n = 0;
            repeat (400)
            begin
                @(posedge core_clk_in);
                #1 n += tick;
            end
            check("ticks", 24'(n), 24'(ticks[i]));
        end
        wr(3'h3, 8'h1c);
        wr(3'h4, 8'h10);
        wr(3'h6, 8'h07);
        idle(3);
        check("bufs temp", {nbuf, pbuf, temp}, 3'h5);
        wr(3'h4, 8'h08);
        wr(3'h6, 8'h70);
        idle(3);
        check("bufs temp", {nbuf, pbuf, temp}, 3'h3);
        wr(3'h6, 8'h00);
        wr(3'h3, 8'h5c);
        idle(3);
        check("sleep", {nbuf, pbuf, temp, modu, fon}, 5'h01);
        wr(3'h7, 8'h07);
        wr(3'h3, 8'h9c);
        wr(3'h3, 8'h1c);
        wr(3'h4, 8'h00);
        wait_irq();
        rd(3'h4);
        check("eoc", v[1], 1'b1);
        rd_result(24'h7fffff);
        @(posedge core_clk_in);
        irq_ack_in <= 1'b1;
        @(posedge core_clk_in);
        irq_ack_in <= 1'b0;
        wr(3'h7, 8'h03);
        idle(300);
        check("masked irq", irq_out, 1'b0);
        rd(3'h7);
        check("pending req", v[3:0], 4'hb);
        rd(3'h4);
        check("eoc held", v[1], 1'b1);
        wr(3'h7, 8'h0f);
        idle(3);
        check("unmasked irq", irq_out, 1'b1);
        wr(3'h4, 8'h04);
        wr(3'h7, 8'h07);
        pattern <= 2'h0;
        wr(3'h0, 8'h55);
        idle(300);
        check("latched irq", irq_out, 1'b0);
        rd(3'h4);
        check("latched eoc", v[1], 1'b0);
        rd_result(24'h7fffff);
        wr(3'h4, 8'h00);
        wait_irq();
        rd_result(24'h800000);
        // alternating bitstream averages to zero
        pattern <= 2'h2;
        wr(3'h7, 8'h07);
        idle(2);
        wait_irq();
        wr(3'h7, 8'h07);
        idle(2);
        wait_irq();
        rd_result(24'h000000);
        report_and_stop();
    end
endmodule // delta_sigma_adc_control_tb_top

// File: pkg/adc_ctrl_defines.svh
// Functional notes
// [R1] power-off forces full power-down of converter
// [R2] regulator follows enable; bandgap when regulator/powered
// [R3] sleep keeps amp, bandgap; rest off (code also keeps filter on in sleep)
// [R4] all bits clear: normal continuous conversion
// [R5] filter-reset holds sinc filter, modulator stays on
// [R6] reset pulse high-low starts fresh conversion
// [R7] reference buffers follow own enable bits
// [R8] temperature sensor on when channel selects it
// [R9] completion sets end-of-conversion flag
// [R10] completion sets converter interrupt request
// [R11] interrupt needs global and converter enables
// [R12] result registers overwritten by each conversion
// [R13] latch bit freezes result, discards new ones
// [R14] software aims converter clock near 4MHz
// [R15] result is 24-bit two's complement
// [R16] results saturate at 0x7fffff and 0x800000
// [R17] software reads low, mid, high bytes
// [R18] reference select picks internal or external pair
// [R19] software configures, powers up, pulses reset
// [R20] end-of-conversion flag cleared only by software
// [R21] latch blocks interrupt and flag updates
// [R22] divider n gives sys/2/(n+1); 31 undivided
// [R23] oversampling code selects ratio 16384 down to 128
// [R24] interrupt request pending until serviced or cleared
`ifndef ADC_CTRL_DEFINES_SVH
`define ADC_CTRL_DEFINES_SVH
`define ADDR_RESULT_LOW 3'h0
`define ADDR_RESULT_MID 3'h1
`define ADDR_RESULT_HIGH 3'h2
`define ADDR_CONTROL_0 3'h3
`define ADDR_CONTROL_1 3'h4
`define ADDR_CLOCK_SELECT 3'h5
`define ADDR_CHANNEL_SEL 3'h6
`define ADDR_POWER_IRQ 3'h7
`define C0_RESET 8'h20
`define C0_FILTER_RESET_BIT 7
`define C0_SLEEP_BIT 6
`define C0_POWER_OFF_BIT 5
`define C0_OSR_LSB 2
`define C0_REF_SEL_BIT 0
`define C1_NEG_BUF_BIT 4
`define C1_POS_BUF_BIT 3
`define C1_LATCH_BIT 2
`define C1_EOC_BIT 1
`define PI_REG_EN_BIT 0
`define PI_GLOBAL_EN_BIT 1
`define PI_CONV_EN_BIT 2
`define PI_REQ_BIT 3
`define DIV_BYPASS 5'h1f
`define OSR_BASE_LOG2 5'he
`define SCALE_SHIFT_BASE 5'h09
`define TEMP_CH_POS 4'h7
`define TEMP_CH_NEG 4'h7
`define RESULT_MAX 24'h7fffff
`define RESULT_MIN 24'h800000
`endif

// File: pkg/adc_ctrl_pkg.sv
package adc_ctrl_pkg;
    typedef enum logic [2:0] {
        MODE_DOWN = 3'h1,
        MODE_SLEEP = 3'h2,
        MODE_RUN = 3'h4
    } conv_mode_e;
endpackage

// File: verilog/conv_clock_div.sv
`timescale 1ns/1ps
`include "adc_ctrl_defines.svh"
module conv_clock_div (
    input wire logic core_clk_in,
    input wire logic rst_in,
    input wire logic [4:0] div_code_in,
    output logic tick_out
);
    logic [5:0] cnt_q;
    logic [5:0] cnt_d;
    logic tick_q;
    logic tick_d;
    logic [5:0] limit;

    // sys/2/(n+1): tick every 2*(n+1) cycles; bypass ticks each cycle
    always_comb
    begin
        limit = {div_code_in, 1'b1};
        if (div_code_in == `DIV_BYPASS)
        begin
            cnt_d = 6'h00;
            tick_d = 1'b1; // [R22]
        end
        else if (cnt_q >= limit)
        begin
            cnt_d = 6'h00;
            tick_d = 1'b1; // [R22]
        end
        else
        begin
            cnt_d = cnt_q + 6'h01;
            tick_d = 1'b0;
        end
    end

    always_ff @(posedge core_clk_in or posedge rst_in)
    begin
        if (rst_in)
        begin
            cnt_q <= 6'h00;
            tick_q <= 1'b0;
        end
        else
        begin
            cnt_q <= cnt_d;
            tick_q <= tick_d;
        end
    end

    assign tick_out = tick_q;

    div_period_a: assert property (@(posedge core_clk_in) disable iff (rst_in)
        (tick_q && div_code_in != `DIV_BYPASS && $stable(div_code_in))
        |=> !tick_q) // [R22]
        else $error("divided tick on consecutive cycles");
endmodule // conv_clock_div

// File: verilog/delta_sigma_adc_control.sv
// Implementation choices: the register offsets and strobed register access.
`timescale 1ns/1ps
`include "adc_ctrl_defines.svh"
module delta_sigma_adc_control (
    input wire logic core_clk_in,
    input wire logic rst_in,
    input wire logic [2:0] addr_in,
    input wire logic [7:0] wdata_in,
    input wire logic wr_in,
    input wire logic rd_in,
    output logic [7:0] rdata_out,
    input wire logic mod_bit_in,
    input wire logic irq_ack_in,
    output logic irq_out,
    output logic bandgap_on_out,
    output logic regulator_on_out,
    output logic cm_gen_on_out,
    output logic amp_on_out,
    output logic modulator_on_out,
    output logic temp_sensor_on_out,
    output logic neg_ref_buffer_on_out,
    output logic pos_ref_buffer_on_out,
    output logic filter_on_out,
    output logic filter_hold_out,
    output logic reference_pair_sel_out,
    output logic conv_clk_tick_out
);
    // modulator bit is an analog-side signal: two-stage sync
    logic mod_s1_q;
    logic mod_s2_q;
    logic [7:0] ctl0_q, ctl0_d;
    logic [7:0] ctl1_q, ctl1_d;
    logic [4:0] div_q, div_d;
    logic [7:0] chan_q, chan_d;
    logic [3:0] pwr_q, pwr_d;
    logic [23:0] result_q, result_d;
    logic [7:0] rdata_q, rdata_d;
    logic [14:0] dec_cnt_q, dec_cnt_d;
    logic signed [25:0] acc_q, acc_d;
    logic [7:0] out_q, out_d;
    logic tick;
    adc_ctrl_pkg::conv_mode_e mode;
    logic [14:0] osr_len;
    logic done;
    logic signed [25:0] acc_next;
    logic [4:0] shift;
    logic signed [25:0] scaled;
    logic [23:0] sample;
    logic latch_on;

    conv_clock_div u_div (
        .core_clk_in(core_clk_in),
        .rst_in(rst_in),
        .div_code_in(div_q),
        .tick_out(tick)
    );

    always_comb
    begin
        if (ctl0_q[`C0_POWER_OFF_BIT])
            mode = adc_ctrl_pkg::MODE_DOWN; // [R1]
        else if (ctl0_q[`C0_SLEEP_BIT])
            mode = adc_ctrl_pkg::MODE_SLEEP; // [R3]
        else
            mode = adc_ctrl_pkg::MODE_RUN; // [R4] [R5]
    end

    always_comb
    begin
        // ratio = 2^(14 - code)
        osr_len = 15'(15'h0001 << (`OSR_BASE_LOG2 -
            {2'b00, ctl0_q[`C0_OSR_LSB +: 3]})); // [R23]
        latch_on = ctl1_q[`C1_LATCH_BIT];
        acc_next = acc_q + (mod_s2_q ? 26'sd1 : -26'sd1);
        // count * 2^23 / ratio: shift by 9 + code
        shift = `SCALE_SHIFT_BASE + {2'b00, ctl0_q[`C0_OSR_LSB +: 3]};
        scaled = acc_next << shift;
        done = 1'b0;
        sample = 24'h000000;
        dec_cnt_d = dec_cnt_q;
        acc_d = acc_q;
        if (mode != adc_ctrl_pkg::MODE_RUN ||
            ctl0_q[`C0_FILTER_RESET_BIT])
        begin
            dec_cnt_d = 15'h0000; // [R5] [R6]
            acc_d = 26'sd0;
        end
        else if (tick)
        begin
            if (dec_cnt_q == osr_len - 15'h0001)
            begin
                done = 1'b1; // [R4]
                dec_cnt_d = 15'h0000;
                acc_d = 26'sd0;
                // scale bipolar count to 24-bit two's complement
                if (scaled > 26'sd8388607)
                    sample = `RESULT_MAX; // [R16]
                else if (scaled < -26'sd8388608)
                    sample = `RESULT_MIN; // [R16]
                else
                    sample = 24'(scaled); // [R15]
            end
            else
            begin
                dec_cnt_d = dec_cnt_q + 15'h0001;
                acc_d = acc_next;
            end
        end
    end

    always_comb
    begin
        ctl0_d = ctl0_q;
        ctl1_d = ctl1_q;
        div_d = div_q;
        chan_d = chan_q;
        pwr_d = pwr_q;
        result_d = result_q;
        if (wr_in)
        begin
            unique case (addr_in)
                `ADDR_CONTROL_0: ctl0_d = wdata_in & 8'hfd;
                `ADDR_CONTROL_1: ctl1_d = {wdata_in[7:2],
                    ctl1_q[`C1_EOC_BIT] & wdata_in[`C1_EOC_BIT],
                    1'b0}; // [R20]
                `ADDR_CLOCK_SELECT: div_d = wdata_in[4:0];
                `ADDR_CHANNEL_SEL: chan_d = wdata_in;
                `ADDR_POWER_IRQ: pwr_d = {pwr_q[`PI_REQ_BIT] &
                    wdata_in[`PI_REQ_BIT], wdata_in[2:0]}; // [R24]
                default: ;
            endcase
        end
        if (irq_ack_in)
            pwr_d[`PI_REQ_BIT] = 1'b0; // [R24]
        // set beats clear in the same cycle
        if (done && !latch_on)
        begin
            result_d = sample; // [R12]
            ctl1_d[`C1_EOC_BIT] = 1'b1; // [R9]
            pwr_d[`PI_REQ_BIT] = 1'b1; // [R10]
        end // latched: no update, no flag [R13] [R21]
        unique case (addr_in)
            `ADDR_RESULT_LOW: rdata_d = result_q[7:0];
            `ADDR_RESULT_MID: rdata_d = result_q[15:8];
            `ADDR_RESULT_HIGH: rdata_d = result_q[23:16];
            `ADDR_CONTROL_0: rdata_d = ctl0_q;
            `ADDR_CONTROL_1: rdata_d = ctl1_q;
            `ADDR_CLOCK_SELECT: rdata_d = {3'h0, div_q};
            `ADDR_CHANNEL_SEL: rdata_d = chan_q;
            `ADDR_POWER_IRQ: rdata_d = {4'h0, pwr_q};
            default: rdata_d = 8'h00;
        endcase
        if (!rd_in)
            rdata_d = 8'h00;
    end

    always_comb
    begin
        out_d[0] = pwr_q[`PI_REG_EN_BIT]; // [R2]
        out_d[1] = pwr_q[`PI_REG_EN_BIT] ||
            mode != adc_ctrl_pkg::MODE_DOWN; // [R2]
        out_d[2] = mode != adc_ctrl_pkg::MODE_DOWN; // amp [R3]
        out_d[3] = mode == adc_ctrl_pkg::MODE_RUN; // modulator, cm [R4]
        out_d[4] = mode == adc_ctrl_pkg::MODE_RUN &&
            (chan_q[3:0] == `TEMP_CH_POS ||
            chan_q[7:4] == `TEMP_CH_NEG); // [R8]
        out_d[5] = mode == adc_ctrl_pkg::MODE_RUN &&
            ctl1_q[`C1_NEG_BUF_BIT]; // [R7]
        out_d[6] = mode == adc_ctrl_pkg::MODE_RUN &&
            ctl1_q[`C1_POS_BUF_BIT]; // [R7]
        out_d[7] = pwr_q[`PI_REQ_BIT] && pwr_q[`PI_GLOBAL_EN_BIT] &&
            pwr_q[`PI_CONV_EN_BIT]; // [R11]
    end

    logic hold_q;
    logic filt_q;
    logic ref_q;
    logic tick_q;

    always_ff @(posedge core_clk_in or posedge rst_in)
    begin
        if (rst_in)
        begin
            mod_s1_q <= 1'b0;
            mod_s2_q <= 1'b0;
            ctl0_q <= `C0_RESET;
            ctl1_q <= 8'h00;
            div_q <= 5'h00;
            chan_q <= 8'h00;
            pwr_q <= 4'h0;
            result_q <= 24'h000000;
            rdata_q <= 8'h00;
            dec_cnt_q <= 15'h0000;
            acc_q <= 26'sd0;
            out_q <= 8'h00;
            hold_q <= 1'b0;
            filt_q <= 1'b0;
            ref_q <= 1'b0;
            tick_q <= 1'b0;
        end
        else
        begin
            mod_s1_q <= mod_bit_in;
            mod_s2_q <= mod_s1_q;
            ctl0_q <= ctl0_d;
            ctl1_q <= ctl1_d;
            div_q <= div_d;
            chan_q <= chan_d;
            pwr_q <= pwr_d;
            result_q <= result_d;
            rdata_q <= rdata_d;
            dec_cnt_q <= dec_cnt_d;
            acc_q <= acc_d;
            out_q <= out_d;
            hold_q <= mode == adc_ctrl_pkg::MODE_RUN &&
                ctl0_q[`C0_FILTER_RESET_BIT]; // [R5]
            filt_q <= mode != adc_ctrl_pkg::MODE_DOWN; // [R1] [R3]
            ref_q <= ctl0_q[`C0_REF_SEL_BIT]; // [R18]
            tick_q <= tick;
        end
    end

    assign rdata_out = rdata_q;
    assign regulator_on_out = out_q[0];
    assign bandgap_on_out = out_q[1];
    assign amp_on_out = out_q[2];
    assign modulator_on_out = out_q[3];
    assign cm_gen_on_out = out_q[3];
    assign temp_sensor_on_out = out_q[4];
    assign neg_ref_buffer_on_out = out_q[5];
    assign pos_ref_buffer_on_out = out_q[6];
    assign irq_out = out_q[7];
    assign filter_hold_out = hold_q;
    assign filter_on_out = filt_q;
    assign reference_pair_sel_out = ref_q;
    assign conv_clk_tick_out = tick_q;

    power_down_a: assert property (@(posedge core_clk_in) disable iff (rst_in)
        ctl0_q[`C0_POWER_OFF_BIT] |=> !amp_on_out && !modulator_on_out &&
        !filter_on_out && !pos_ref_buffer_on_out) // [R1]
        else $error("converter not fully off in power-down");
    bandgap_on_a: assert property (@(posedge core_clk_in) disable iff (rst_in)
        (pwr_q[`PI_REG_EN_BIT] || !ctl0_q[`C0_POWER_OFF_BIT])
        |=> bandgap_on_out) // [R2]
        else $error("bandgap off while needed");
    sleep_state_a: assert property (@(posedge core_clk_in) disable iff (rst_in)
        (!ctl0_q[`C0_POWER_OFF_BIT] && ctl0_q[`C0_SLEEP_BIT])
        |=> amp_on_out && !modulator_on_out && !temp_sensor_on_out) // [R3]
        else $error("sleep mode power state wrong");
    hold_no_done_a: assert property (@(posedge core_clk_in) disable iff (rst_in)
        ctl0_q[`C0_FILTER_RESET_BIT] |-> !done && dec_cnt_d == 15'h0) // [R5]
        else $error("conversion completed while filter held");
    eoc_set_a: assert property (@(posedge core_clk_in) disable iff (rst_in)
        (done && !latch_on) |=> ctl1_q[`C1_EOC_BIT] &&
        pwr_q[`PI_REQ_BIT] && result_q == $past(sample)) // [R9]
        else $error("completion did not set flag and result");
    latch_hold_a: assert property (@(posedge core_clk_in) disable iff (rst_in)
        (latch_on && !wr_in) |=> $stable(result_q) &&
        $stable(ctl1_q[`C1_EOC_BIT])) // [R13]
        else $error("latched result or flag changed");
    eoc_sticky_a: assert property (@(posedge core_clk_in) disable iff (rst_in)
        (ctl1_q[`C1_EOC_BIT] && !(wr_in && addr_in == `ADDR_CONTROL_1))
        |=> ctl1_q[`C1_EOC_BIT]) // [R20]
        else $error("flag cleared without software write");
    irq_gate_a: assert property (@(posedge core_clk_in) disable iff (rst_in)
        irq_out |-> $past(pwr_q[`PI_GLOBAL_EN_BIT]) &&
        $past(pwr_q[`PI_CONV_EN_BIT])) // [R11]
        else $error("interrupt without both enables");
endmodule // delta_sigma_adc_control
